// [core/fsk_buf2.sv]
// two-entry valid/ready buffer
`timescale 1ns/10ps
module fsk_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  logic [WIDTH-1:0] mem [2];
  logic [WIDTH-1:0] next_mem [2];
  logic             wr_ptr, next_wr_ptr;
  logic             rd_ptr, next_rd_ptr;
  logic [1:0]       count, next_count;
  logic             push, pop;

  assign o_in_ready  = (count != 2'h2);
  assign o_out_valid = (count != 2'h0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = i_in_data;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push & ~pop) begin
      next_count = count + 2'h1;
    end else if (pop & ~push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule // fsk_buf2

// [core/fsk_char_datapath.sv]
// character framing, tone modulator, receiver and error flags of the modem
`timescale 1ns/10ps
module fsk_char_datapath
  import fsk_pkg::*;
#(
  parameter int unsigned BIT_CYCLES     = CLK_HZ / BIT_RATE_HZ,
  parameter int unsigned SPLIT_CYCLES   = CLK_HZ / SPLIT_HZ,
  parameter int unsigned CARRIER_CYCLES = CLK_HZ / CARRIER_MIN_HZ,
  parameter int unsigned STEP_MARK1     = CLK_HZ / (MARK1_HZ * TONE_STEPS),
  parameter int unsigned STEP_SPACE1    = CLK_HZ / (SPACE1_HZ * TONE_STEPS),
  parameter int unsigned STEP_MARK2     = CLK_HZ / (MARK2_HZ * TONE_STEPS),
  parameter int unsigned STEP_SPACE2    = CLK_HZ / (SPACE2_HZ * TONE_STEPS)
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_serial_mode,
  input  wire logic       i_char_length_select,
  input  wire logic       i_parity_sense_select,
  input  wire logic       i_tone_set_select,
  input  wire logic       i_terminal_serial_in,
  input  wire logic       i_transmit_on_input,
  input  wire logic       i_line_receive_input,
  input  wire fsk_io_s    i_io,
  output logic      [3:0] o_io_data,
  output logic            o_io_data_oe_b,
  output logic      [3:0] o_tone_step_outputs,
  output logic            o_tone_step_oe_b,
  output logic            o_terminal_serial_out,
  output logic            o_carrier_present_out
);

  localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] BIT_HALF  = CW'(BIT_CYCLES / 2);
  localparam logic [CW-1:0] SPLIT_CNT = CW'(SPLIT_CYCLES);
  localparam logic [CW-1:0] CARR_CNT  = CW'(CARRIER_CYCLES);

  function automatic logic [CW-1:0] step_div(input logic bitv,
                                            input logic tone2);
    if (tone2) begin
      step_div = bitv ? CW'(STEP_MARK2) : CW'(STEP_SPACE2);
    end else begin
      step_div = bitv ? CW'(STEP_MARK1) : CW'(STEP_SPACE1);
    end
  endfunction

  // pin synchronisers and edge/level filters
  logic [6:0] pins, s1, s2, s3, next_s1, next_s2, next_s3;
  logic       term_f, next_term_f, line_f, next_line_f;
  fsk_strap_s strap;
  logic       transmit_on_input;

  assign pins  = {i_serial_mode, i_char_length_select,
                  i_parity_sense_select, i_tone_set_select,
                  i_terminal_serial_in, i_transmit_on_input,
                  i_line_receive_input};
  assign strap = s2[6:3];
  assign transmit_on_input   = s2[1];

  always_comb begin
    next_s1     = pins;
    next_s2     = s1;
    next_s3     = s2;
    // a level counts only once two samples agree, so glitches are dropped
    next_term_f = (s2[2] == s3[2]) ? s2[2] : term_f;
    next_line_f = (s2[0] == s3[0]) ? s2[0] : line_f;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1     <= 7'h00;
      s2     <= 7'h00;
      s3     <= 7'h00;
      term_f <= 1'b1;
      line_f <= 1'b0;
    end else begin
      s1     <= next_s1;
      s2     <= next_s2;
      s3     <= next_s3;
      term_f <= next_term_f;
      line_f <= next_line_f;
    end
  end

  // demodulator: period between rising edges decides mark or space
  logic          line_prev, next_line_prev;
  logic [CW-1:0] per_cnt, next_per_cnt;
  logic          demod, next_demod;
  logic          carrier;

  assign carrier = (per_cnt < CARR_CNT);

  always_comb begin
    next_line_prev = line_f;
    next_demod     = demod;
    next_per_cnt   = carrier ? per_cnt + CW'(1) : per_cnt;
    if (line_f & ~line_prev) begin
      next_demod   = (per_cnt > SPLIT_CNT);
      next_per_cnt = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_prev <= 1'b0;
      per_cnt   <= CARR_CNT;
      demod     <= 1'b1;
    end else begin
      line_prev <= next_line_prev;
      per_cnt   <= next_per_cnt;
      demod     <= next_demod;
    end
  end

  // transmit buffer: stalls hold words until the framer takes them
  logic       tx_push, tx_space, tx_valid, tx_pop;
  logic [7:0] tx_word;
  logic [3:0] hi_nib;
  logic       fmt, nf_on, nf_bit;
  logic [2:0] tx_len, rx_len;
  logic       rx_arm;

  fsk_buf2 #(.WIDTH(8)) u_txbuf (
    .i_clock    (i_clock),
    .i_rst_b    (i_rst_b),
    .i_in_valid (tx_push),
    .o_in_ready (tx_space),
    .i_in_data  ({hi_nib, i_io.data}),
    .o_out_valid(tx_valid),
    .i_out_ready(tx_pop),
    .o_out_data (tx_word)
  );

  // transmit framer
  fsk_frame_e    tx_st, next_tx_st;
  logic [CW-1:0] tx_tmr, next_tx_tmr;
  logic [2:0]    tx_idx, next_tx_idx;
  logic [2:0]    tx_left, next_tx_left;
  logic [7:0]    tx_sh, next_tx_sh;
  logic          tx_line, tx_par;

  assign tx_par = ^tx_sh[6:0] ^ strap.par_odd;

  always_comb begin
    unique case (tx_st)
      FSK_START: tx_line = 1'b0;
      FSK_DATA:  tx_line = (tx_idx == 3'h7 && !strap.char8) ? tx_par
                                                           : tx_sh[tx_idx];
      default:   tx_line = 1'b1;
    endcase
  end

  always_comb begin
    next_tx_st   = tx_st;
    next_tx_tmr  = tx_tmr + CW'(1);
    next_tx_idx  = tx_idx;
    next_tx_left = tx_left;
    next_tx_sh   = tx_sh;
    tx_pop       = 1'b0;
    if (tx_st == FSK_IDLE) begin
      next_tx_tmr = '0;
      if (!strap.serial_mode && fmt && tx_valid) begin
        tx_pop       = 1'b1;
        next_tx_sh   = tx_word;
        next_tx_left = tx_len;
        next_tx_st   = FSK_START;
      end
    end else if (tx_tmr == BIT_LAST) begin
      next_tx_tmr = '0;
      unique case (tx_st)
        FSK_START: begin
          next_tx_idx = 3'h0;
          next_tx_st  = FSK_DATA;
        end
        FSK_DATA: begin
          if (tx_idx != 3'h7) begin
            next_tx_idx = tx_idx + 3'h1;
          end else if (tx_left != 3'h0 && tx_valid) begin
            // inner characters follow with no framing between them
            tx_pop       = 1'b1;
            next_tx_sh   = tx_word;
            next_tx_left = tx_left - 3'h1;
            next_tx_idx  = 3'h0;
          end else begin
            // running dry mid message closes the frame early
            next_tx_st = FSK_STOP;
          end
        end
        default: next_tx_st = FSK_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_st   <= FSK_IDLE;
      tx_tmr  <= '0;
      tx_idx  <= 3'h0;
      tx_left <= 3'h0;
      tx_sh   <= 8'h00;
    end else begin
      tx_st   <= next_tx_st;
      tx_tmr  <= next_tx_tmr;
      tx_idx  <= next_tx_idx;
      tx_left <= next_tx_left;
      tx_sh   <= next_tx_sh;
    end
  end

  // tone step generator
  logic          mod_bit, mod_on;
  logic [CW-1:0] step_cnt, next_step_cnt;
  logic [3:0]    phase, next_phase;
  logic          oe_b, next_oe_b;

  always_comb begin
    if (strap.serial_mode) begin
      mod_bit = term_f;
      mod_on  = transmit_on_input;
    end else if (fmt) begin
      mod_bit = tx_line;
      mod_on  = (tx_st != FSK_IDLE);
    end else begin
      mod_bit = nf_bit;
      mod_on  = nf_on;
    end
    next_oe_b     = ~mod_on;
    next_step_cnt = step_cnt + CW'(1);
    next_phase    = phase;
    if (!mod_on) begin
      next_step_cnt = '0;
      next_phase    = 4'h0;
    end else if (next_step_cnt >= step_div(mod_bit, strap.tone2)) begin
      next_step_cnt = '0;
      next_phase    = phase + 4'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      step_cnt <= '0;
      phase    <= 4'h0;
      oe_b     <= 1'b1;
    end else begin
      step_cnt <= next_step_cnt;
      phase    <= next_phase;
      oe_b     <= next_oe_b;
    end
  end

  assign o_tone_step_outputs = phase;
  assign o_tone_step_oe_b    = oe_b;

  // receiver framer
  fsk_frame_e    rx_st, next_rx_st;
  logic [CW-1:0] rx_tmr, next_rx_tmr;
  logic [2:0]    rx_idx, next_rx_idx;
  logic [2:0]    rx_left, next_rx_left;
  logic [7:0]    rx_sh, next_rx_sh;
  logic          char_done, stop_bad, lost;

  always_comb begin
    next_rx_st   = rx_st;
    next_rx_tmr  = rx_tmr + CW'(1);
    next_rx_idx  = rx_idx;
    next_rx_left = rx_left;
    next_rx_sh   = rx_sh;
    char_done    = 1'b0;
    stop_bad     = 1'b0;
    lost         = 1'b0;
    if (rx_st == FSK_IDLE) begin
      next_rx_tmr = '0;
      if (!strap.serial_mode && rx_arm && carrier && !demod) begin
        next_rx_st = FSK_START;
      end
    end else if (!carrier) begin
      lost       = 1'b1;
      next_rx_st = FSK_IDLE;
    end else if (rx_st == FSK_START) begin
      if (rx_tmr == BIT_HALF) begin
        next_rx_tmr  = '0;
        next_rx_idx  = 3'h0;
        next_rx_left = rx_len;
        next_rx_st   = demod ? FSK_IDLE : FSK_DATA;
      end
    end else if (rx_tmr == BIT_LAST) begin
      next_rx_tmr = '0;
      if (rx_st == FSK_DATA) begin
        next_rx_sh  = {demod, rx_sh[7:1]};
        next_rx_idx = rx_idx + 3'h1;
        if (rx_idx == 3'h7) begin
          char_done    = 1'b1;
          next_rx_left = rx_left - 3'h1;
          if (rx_left == 3'h0) begin
            next_rx_st = FSK_STOP;
          end
        end
      end else begin
        stop_bad   = ~demod;
        next_rx_st = FSK_IDLE;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_st   <= FSK_IDLE;
      rx_tmr  <= '0;
      rx_idx  <= 3'h0;
      rx_left <= 3'h0;
      rx_sh   <= 8'h00;
    end else begin
      rx_st   <= next_rx_st;
      rx_tmr  <= next_rx_tmr;
      rx_idx  <= next_rx_idx;
      rx_left <= next_rx_left;
      rx_sh   <= next_rx_sh;
    end
  end

  // host command decode, receive buffer and error flags
  logic [7:0] rx_char, rx_buf, next_rx_buf;
  logic       rx_full, next_rx_full;
  fsk_flags_s flags, next_flags;
  logic [3:0] next_hi_nib, dout, next_dout;
  logic       next_fmt, next_nf_on, next_nf_bit, next_rx_arm;
  logic [2:0] next_tx_len, next_rx_len;
  logic       dout_oe_b, next_dout_oe_b, cmd_ok, par_bad;
  logic       term_out, next_term_out, carr_out, next_carr_out;

  assign rx_char = {demod, rx_sh[7:1]};
  assign cmd_ok  = i_io.strobe & ~strap.serial_mode;
  assign par_bad = ~strap.char8 & (^rx_char ^ strap.par_odd);
  // a load refused while the buffer is full is simply lost
  assign tx_push = cmd_ok & (i_io.cmd == CMD_LOAD_LO) & fmt;

  always_comb begin
    next_hi_nib    = hi_nib;
    next_fmt       = fmt;
    next_nf_on     = nf_on;
    next_nf_bit    = nf_bit;
    next_tx_len    = tx_len;
    next_rx_len    = rx_len;
    next_rx_arm    = rx_arm;
    next_rx_buf    = rx_buf;
    next_rx_full   = rx_full;
    next_flags     = flags;
    next_dout      = dout;
    next_dout_oe_b = 1'b1;
    if (cmd_ok) begin
      unique case (i_io.cmd)
        CMD_RECV_REQ: begin
          next_rx_arm = i_io.data[SEC_FMT];
          next_rx_len = i_io.data[2:0];
          next_flags  = FLAGS_RST;
        end
        CMD_SEND_REQ: begin
          next_fmt    = i_io.data[SEC_FMT];
          next_tx_len = i_io.data[2:0];
          next_nf_on  = i_io.data[SEC_ON];
          next_nf_bit = i_io.data[SEC_BIT];
        end
        CMD_LOAD_HI: next_hi_nib = i_io.data;
        CMD_READ_HI: begin
          next_dout      = rx_buf[7:4];
          next_dout_oe_b = 1'b0;
        end
        CMD_READ_LO: begin
          next_dout      = rx_buf[3:0];
          next_dout_oe_b = 1'b0;
          next_rx_full   = 1'b0;
        end
        CMD_READ_STAT: begin
          next_dout      = {rx_full, ~tx_space, carrier, demod};
          next_dout_oe_b = 1'b0;
        end
        CMD_READ_ERR: begin
          next_dout      = flags;
          next_dout_oe_b = 1'b0;
        end
        default: next_dout_oe_b = 1'b1;
      endcase
    end
    // a new flag event beats a flag clear in the same cycle
    if (char_done) begin
      if (rx_full) begin
        next_flags.overflow = 1'b1;
      end else begin
        next_rx_buf  = strap.char8 ? rx_char : (rx_char & PAR_MASK7);
        next_rx_full = 1'b1;
      end
      // built on the cleared value so a clear in this cycle still counts
      next_flags.parity_err = next_flags.parity_err | par_bad;
    end
    if (stop_bad) begin
      next_flags.stop_missing = 1'b1;
    end
    if (lost) begin
      next_flags.carrier_lost = 1'b1;
    end
    next_term_out = strap.serial_mode ? demod : 1'b1;
    next_carr_out = strap.serial_mode & carrier;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_nib    <= 4'h0;
      fmt       <= 1'b0;
      nf_on     <= 1'b0;
      nf_bit    <= 1'b1;
      tx_len    <= 3'h0;
      rx_len    <= 3'h0;
      rx_arm    <= 1'b0;
      rx_buf    <= RXBUF_RST;
      rx_full   <= 1'b0;
      flags     <= FLAGS_RST;
      dout      <= 4'h0;
      dout_oe_b <= 1'b1;
      term_out  <= 1'b1;
      carr_out  <= 1'b0;
    end else begin
      hi_nib    <= next_hi_nib;
      fmt       <= next_fmt;
      nf_on     <= next_nf_on;
      nf_bit    <= next_nf_bit;
      tx_len    <= next_tx_len;
      rx_len    <= next_rx_len;
      rx_arm    <= next_rx_arm;
      rx_buf    <= next_rx_buf;
      rx_full   <= next_rx_full;
      flags     <= next_flags;
      dout      <= next_dout;
      dout_oe_b <= next_dout_oe_b;
      term_out  <= next_term_out;
      carr_out  <= next_carr_out;
    end
  end

  assign o_io_data             = dout;
  assign o_io_data_oe_b        = dout_oe_b;
  assign o_terminal_serial_out = term_out;
  assign o_carrier_present_out = carr_out;

endmodule // fsk_char_datapath

// [core/fsk_pkg.sv]
// shared constants, command codes and bus, strap, flag and frame types of the fsk modem datapath
package fsk_pkg;

  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned BIT_RATE_HZ    = 1200;
  localparam int unsigned MARK1_HZ       = 1300;
  localparam int unsigned SPACE1_HZ      = 2100;
  localparam int unsigned MARK2_HZ       = 1200;
  localparam int unsigned SPACE2_HZ      = 2200;
  localparam int unsigned SPLIT_HZ       = 1700;
  localparam int unsigned CARRIER_MIN_HZ = 600;
  localparam int unsigned TONE_STEPS     = 16;
  localparam int unsigned CW             = 20;

  // primary command nibble, bus polarity
  localparam logic [3:0] CMD_RECV_REQ  = 4'h6;
  localparam logic [3:0] CMD_SEND_REQ  = 4'h4;
  localparam logic [3:0] CMD_LOAD_HI   = 4'h9;
  localparam logic [3:0] CMD_LOAD_LO   = 4'h8;
  localparam logic [3:0] CMD_READ_HI   = 4'he;
  localparam logic [3:0] CMD_READ_LO   = 4'hb;
  localparam logic [3:0] CMD_READ_STAT = 4'hd;
  localparam logic [3:0] CMD_READ_ERR  = 4'h7;

  // secondary command fields
  localparam int unsigned SEC_FMT  = 3;
  localparam int unsigned SEC_ON   = 0;
  localparam int unsigned SEC_BIT  = 1;

  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] RXBUF_RST = 8'h00;
  localparam logic [7:0] PAR_MASK7 = 8'h7f;

  typedef struct packed {
    logic       strobe;
    logic [3:0] cmd;
    logic [3:0] data;
  } fsk_io_s;

  typedef struct packed {
    logic serial_mode;
    logic char8;
    logic par_odd;
    logic tone2;
  } fsk_strap_s;

  // bit 3 .. bit 0 of the error flag register
  typedef struct packed {
    logic carrier_lost;
    logic stop_missing;
    logic parity_err;
    logic overflow;
  } fsk_flags_s;

  typedef enum logic [1:0] {
    FSK_IDLE  = 2'b00,
    FSK_START = 2'b01,
    FSK_DATA  = 2'b10,
    FSK_STOP  = 2'b11
  } fsk_frame_e;

endpackage

// [testbench/fsk_char_datapath_asserts.sv]
// port checker for the fsk character datapath
`timescale 1ns/10ps
module fsk_chk
  import fsk_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  input wire logic       i_serial_mode,
  input wire logic       i_transmit_on_input,
  input wire fsk_io_s    i_io,
  input wire logic [3:0] o_io_data,
  input wire logic       o_io_data_oe_b,
  input wire logic       o_tone_step_oe_b,
  input wire logic       o_terminal_serial_out,
  input wire logic       o_carrier_present_out
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic rd;
  assign rd = i_io.strobe && (i_io.cmd inside {CMD_READ_HI, CMD_READ_LO,
              CMD_READ_STAT, CMD_READ_ERR});
  // straps pass two sync stages, so repetitions allow for that lag
  chk_flag_read_oe: assert property (
    ((!i_serial_mode)[*3] ##0 (i_io.strobe && i_io.cmd == CMD_READ_ERR))
    |=> !o_io_data_oe_b) else $error("flag read not answered");
  chk_oe_no_cause: assert property (
    !rd |=> o_io_data_oe_b) else $error("bus driven without a read");
  chk_serial_refuse: assert property (
    (i_serial_mode[*3] ##0 rd) |=> o_io_data_oe_b)
    else $error("read answered in serial mode");
  chk_data_hold: assert property (
    !$past(rd) |-> $stable(o_io_data)) else $error("read data moved");
  chk_host_cd_low: assert property (
    (!i_serial_mode)[*5] |-> !o_carrier_present_out)
    else $error("carrier out active in host mode");
  chk_host_so_idle: assert property (
    (!i_serial_mode)[*5] |-> o_terminal_serial_out)
    else $error("serial out active in host mode");
  chk_ton_float: assert property (
    (i_serial_mode && !i_transmit_on_input)[*5] |-> o_tone_step_oe_b)
    else $error("tone outputs driven while off");
  chk_ton_drive: assert property (
    (i_serial_mode && i_transmit_on_input)[*6] |-> !o_tone_step_oe_b)
    else $error("tone outputs float while on");
  cover property (rd ##1 !o_io_data_oe_b);
  cover property (i_serial_mode && o_carrier_present_out);
  cover property (!i_serial_mode && !o_tone_step_oe_b);
endmodule // fsk_chk

bind fsk_char_datapath fsk_chk chk_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
  .i_serial_mode(i_serial_mode), .i_transmit_on_input(i_transmit_on_input),
  .i_io(i_io), .o_io_data(o_io_data), .o_io_data_oe_b(o_io_data_oe_b),
  .o_tone_step_oe_b(o_tone_step_oe_b),
  .o_terminal_serial_out(o_terminal_serial_out),
  .o_carrier_present_out(o_carrier_present_out));

// [testbench/fsk_cpu_model.sv]
// cpu model issuing commands on the shared 4-bit bus
`timescale 1ns/10ps
module fsk_cpu_model
  import fsk_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic [3:0] i_io_data,
  input  wire logic       i_io_data_oe_b,
  output fsk_io_s         o_io
);
  initial o_io = '0;
  // the bus is inverted against the accumulator in both directions
  task automatic put(input logic [3:0] c, input logic [3:0] acc);
    @(negedge i_clock);
    o_io <= '{1'b1, c, ~acc};
    @(negedge i_clock);
    o_io.strobe <= 1'b0;
  endtask
  // no answer reads as unknown so a silent device never matches
  task automatic get(input logic [3:0] c, output logic [3:0] acc);
    put(c, 4'h0);
    acc = i_io_data_oe_b ? 4'hx : ~i_io_data;
  endtask
endmodule // fsk_cpu_model

// [testbench/test_fsk_char_datapath.sv]
// self-checking bench: tone loopback from modulator to receiver
`timescale 1ns/10ps
module test_fsk_char_datapath
  import fsk_pkg::*;
;
  localparam int BITC = 512;
  localparam int SPLITC = 110;
  localparam int CARRC = 400;
  logic       clk = 0, rst_b = 0, smode = 0, char_length_select = 1, ps = 0, fs = 0;
  logic       tsi = 1, transmit_on_input = 0, line = 0, io_oe_b, tone_oe_b, tso, cdo;
  logic [3:0] io_d, tone;
  fsk_io_s    io;
  int         failures = 0, compares = 0, seed = 2148;
  logic [7:0] exp_q[$];

  always #2.5 clk = ~clk;
  // a floating modulator leaves the line quiet, so carrier drops
  always @(negedge clk) line <= tone_oe_b ? 1'b0 : tone[3];

  fsk_char_datapath #(.BIT_CYCLES(BITC), .SPLIT_CYCLES(SPLITC),
    .CARRIER_CYCLES(CARRC), .STEP_MARK1(8), .STEP_SPACE1(5),
    .STEP_MARK2(9), .STEP_SPACE2(4)) dut_u (
    .i_clock(clk), .i_rst_b(rst_b), .i_serial_mode(smode),
    .i_char_length_select(char_length_select), .i_parity_sense_select(ps),
    .i_tone_set_select(fs), .i_terminal_serial_in(tsi),
    .i_transmit_on_input(transmit_on_input), .i_line_receive_input(line), .i_io(io),
    .o_io_data(io_d), .o_io_data_oe_b(io_oe_b), .o_tone_step_outputs(tone),
    .o_tone_step_oe_b(tone_oe_b), .o_terminal_serial_out(tso),
    .o_carrier_present_out(cdo));

  fsk_cpu_model cpu_u (.i_clock(clk), .i_io_data(io_d),
    .i_io_data_oe_b(io_oe_b), .o_io(io));

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(logic [3:0] c, logic [3:0] n);
    cpu_u.put(c, ~n);
  endtask

  task automatic rd(logic [3:0] c, output logic [3:0] n);
    cpu_u.get(c, n);
    n = ~n;
  endtask

  task automatic wait_rx();
    logic [3:0] s;
    s = 4'h0;
    for (int k = 0; k < 4000 && s[3] !== 1'b1; k++) rd(CMD_READ_STAT, s);
    chk("rx full", 1'b1, s[3]);
  endtask

  task automatic rd_char();
    logic [3:0] h, l;
    logic [7:0] e;
    e = exp_q.pop_front();
    rd(CMD_READ_HI, h);
    rd(CMD_READ_LO, l);
    chk("rx char", char_length_select ? e : e & PAR_MASK7, {h, l});
  endtask

  task automatic xfer(int n, int narm, bit each, logic [3:0] ef);
    logic [7:0] b;
    logic [3:0] s;
    cmd(CMD_RECV_REQ, 4'h8 | 4'(narm - 1));
    cmd(CMD_SEND_REQ, 4'h8 | 4'(n - 1));
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      cmd(CMD_LOAD_HI, b[7:4]);
      cmd(CMD_LOAD_LO, b[3:0]);
    end
    if (n == 3) begin
      rd(CMD_READ_STAT, s);
      chk("tx full", 1'b1, s[2]);
    end
    if (each) begin
      for (int i = 0; i < n; i++) begin
        wait_rx();
        rd_char();
      end
    end else begin
      repeat ((n * 9 + 2) * BITC) @(negedge clk);
      rd_char();
      exp_q.delete();
    end
    repeat (4 * BITC) @(negedge clk);
    rd(CMD_READ_ERR, s);
    chk("flags", ef, s);
  endtask

  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    logic [3:0] s;
    logic [7:0] b;
    logic [9:0] fr;
    repeat (10) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
    rd(CMD_READ_ERR, s);
    chk("flags reset", 4'h0, s);
    rd(CMD_READ_STAT, s);
    chk("status reset", 2'b00, s[3:2]);
    for (int i = 0; i < 4; i++) begin
      char_length_select = i[0];
      ps = i[1];
      fs = i[0] ^ i[1];
      repeat (4) @(negedge clk);
      xfer(1, 1, 1, 4'h0);
    end
    char_length_select = 0;
    xfer(3, 3, 1, 4'h0);
    char_length_select = 1;
    xfer(3, 3, 0, 4'h1);
    xfer(1, 2, 1, 4'h8);
    // hand-made frame: odd sense, parity inverted, stop bit low
    char_length_select = 0;
    ps = 1;
    cmd(CMD_RECV_REQ, 4'h8);
    b = 8'($random(seed));
    fr = {1'b0, ^b[6:0], b[6:0], 1'b0};
    for (int k = 0; k < 10; k++) begin
      cmd(CMD_SEND_REQ, {2'b00, fr[k], 1'b1});
      repeat (BITC - 2) @(negedge clk);
    end
    // stop already sampled; the line still spaces, so a false start follows
    rd(CMD_READ_ERR, s);
    chk("frame flags", 4'h6, s);
    cmd(CMD_SEND_REQ, 4'h0);
    repeat (3 * BITC) @(negedge clk);
    rd(CMD_READ_ERR, s);
    chk("lost flags", 4'he, s);
    rd(CMD_READ_LO, s);
    smode = 1;
    transmit_on_input = 1;
    repeat (4) @(negedge clk);
    cmd(CMD_READ_ERR, 4'h0);
    chk("serial refuse", 1'b1, io_oe_b);
    for (int k = 0; k < 8; k++) begin
      tsi = 1'($random(seed));
      repeat (BITC - 4) @(negedge clk);
      chk("serial out", tsi, tso);
      chk("carrier out", 1'b1, cdo);
      repeat (4) @(negedge clk);
    end
    transmit_on_input = 0;
    repeat (2 * BITC) @(negedge clk);
    chk("carrier off", 1'b0, cdo);
    chk("tone float", 1'b1, tone_oe_b);
    tally_and_finish();
  end
endmodule // test_fsk_char_datapath
